// ---- design/pbmc_map.svh ----
// register map, field positions and timing counts of the mode control block
`ifndef PBMC_MAP_SVH
`define PBMC_MAP_SVH

`define PBMC_CLK_MHZ       100
`define PBMC_ADDR_W        8
`define PBMC_ADDR_CTRL     8'h00
`define PBMC_ADDR_STAT     8'h04

`define PBMC_B_RESET       15
`define PBMC_B_LOOPBACK    14
`define PBMC_B_SPEED       13
`define PBMC_B_AN_EN       12
`define PBMC_B_DUPLEX      8

`define PBMC_S_FIXED       0
`define PBMC_S_LINK_LL     1
`define PBMC_S_FAULT_LH    2
`define PBMC_S_RSTDONE_COR 3
`define PBMC_S_DEAD_SC     4

`define PBMC_FIXED_VAL     1'b1
`define PBMC_LOOPBACK_RST  1'b0

`define PBMC_DEAD_US       500
`define PBMC_DEAD_CYC      (`PBMC_DEAD_US * `PBMC_CLK_MHZ)
`define PBMC_SWRST_NS      1000
`define PBMC_SWRST_CYC     ((`PBMC_SWRST_NS * `PBMC_CLK_MHZ + 999) / 1000)
`define PBMC_BOOT_CYC      3

`endif

// ---- design/pbmc_pkg.sv ----
// types shared by the mode control block
package pbmc_pkg;

  typedef enum logic [1:0] {
    PBMC_BOOT  = 2'b00,
    PBMC_RUN   = 2'b01,
    PBMC_SWRST = 2'b11
  } pbmc_fsm_t;

  typedef struct packed {
    logic [3:0] txd;
    logic       tx_en;
    logic [3:0] line_rxd;
    logic       line_rx_dv;
    logic       link_ok;
    logic       remote_fault;
    logic       an_speed_100;
    logic       an_full_duplex;
    logic       strap_an_en;
    logic       strap_speed_100;
    logic       strap_full_duplex;
    logic       fiber_mode_enable;
  } pbmc_pins_t;

  typedef struct packed {
    logic [3:0] rxd;
    logic       rx_dv;
  } pbmc_rx_t;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic an_enable;
    logic loopback;
    logic port_reset;
  } pbmc_mode_t;

  typedef struct packed {
    pbmc_pins_t s1;
    pbmc_pins_t s2;
  } pbmc_sync_st_t;

  typedef struct packed {
    logic val;
  } pbmc_cell_st_t;

  typedef struct packed {
    pbmc_fsm_t   fsm;
    logic [7:0]  rst_cnt;
    logic [15:0] dead_cnt;
    logic        loopback;
    logic        speed_100;
    logic        an_en;
    logic        full_duplex;
    logic        rst_done;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    pbmc_rx_t    rx;
    pbmc_mode_t  mode;
  } pbmc_top_st_t;

endpackage

// ---- design/pbmc_sync.sv ----
// two-flop synchroniser for the pin bundle
`timescale 1ns/1ps
module pbmc_sync (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire pbmc_pkg::pbmc_pins_t pins_in,
  output pbmc_pkg::pbmc_pins_t    pins_out
);
  pbmc_pkg::pbmc_sync_st_t s_r;
  pbmc_pkg::pbmc_sync_st_t s_nxt;

  // first stage feeds only the second stage
  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = pins_in;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pins_out = s_r.s2;
endmodule

// ---- design/pbmc_event_bit.sv ----
// latched status bit, held until a read reports it
`timescale 1ns/1ps
module pbmc_event_bit #(
  parameter bit LOW = 1'b0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic event_in,
  input  wire logic rd_clr,
  input  wire logic reported,
  output logic      val
);
  pbmc_pkg::pbmc_cell_st_t s_r;
  pbmc_pkg::pbmc_cell_st_t s_nxt;

  // only the value the reader saw is released; a new event wins
  always_comb begin
    s_nxt = s_r;
    if (LOW) begin
      s_nxt.val = !event_in && (s_r.val || (rd_clr && !reported));
    end else begin
      s_nxt.val = event_in || (s_r.val && !(rd_clr && reported));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.val <= LOW;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign val = s_r.val;
endmodule

// ---- design/pbmc_top.sv ----
// basic mode control register bank with apb slave and mode outputs
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "pbmc_map.svh"

module pbmc_top #(
  parameter int unsigned DEAD_CYC = `PBMC_DEAD_CYC
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire pbmc_pkg::pbmc_pins_t    pins,
  output pbmc_pkg::pbmc_rx_t           rx,
  output pbmc_pkg::pbmc_mode_t         mode
);
  pbmc_pkg::pbmc_top_st_t s_r;
  pbmc_pkg::pbmc_top_st_t s_nxt;
  pbmc_pkg::pbmc_pins_t   p;

  logic        hit_ctrl;
  logic        hit_stat;
  logic        acc_end;
  logic        wr_ctrl;
  logic        stat_clr;
  logic [15:0] ctrl_word;
  logic [15:0] stat_word;
  logic        link_ll;
  logic        fault_lh;
  logic        rstdone_cor;
  logic        dead_sc;

  pbmc_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pins_in  (pins),
    .pins_out (p)
  );

  assign hit_ctrl = (paddr == `PBMC_ADDR_CTRL);
  assign hit_stat = (paddr == `PBMC_ADDR_STAT);
  // side effects land on the edge that completes the transfer
  assign acc_end  = psel && penable && s_r.pready;
  assign wr_ctrl  = acc_end && pwrite && hit_ctrl;
  assign stat_clr = acc_end && !pwrite && hit_stat;

  pbmc_event_bit #(.LOW(1'b1)) u_link_ll (
    .pclk     (pclk),
    .presetn  (presetn),
    .event_in (!p.link_ok),
    .rd_clr   (stat_clr),
    .reported (s_r.prdata[`PBMC_S_LINK_LL]),
    .val      (link_ll)
  );

  pbmc_event_bit #(.LOW(1'b0)) u_fault_lh (
    .pclk     (pclk),
    .presetn  (presetn),
    .event_in (p.remote_fault),
    .rd_clr   (stat_clr),
    .reported (s_r.prdata[`PBMC_S_FAULT_LH]),
    .val      (fault_lh)
  );

  pbmc_event_bit #(.LOW(1'b0)) u_rstdone_cor (
    .pclk     (pclk),
    .presetn  (presetn),
    .event_in (s_r.rst_done),
    .rd_clr   (stat_clr),
    .reported (s_r.prdata[`PBMC_S_RSTDONE_COR]),
    .val      (rstdone_cor)
  );

  // dead time flag follows the counter, no software clear
  assign dead_sc = (s_r.dead_cnt != 16'h0000);

  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[`PBMC_B_RESET]    = (s_r.fsm != pbmc_pkg::PBMC_RUN);
    ctrl_word[`PBMC_B_LOOPBACK] = s_r.loopback;
    ctrl_word[`PBMC_B_SPEED]    = s_r.speed_100;
    ctrl_word[`PBMC_B_AN_EN]    = s_r.an_en;
    ctrl_word[`PBMC_B_DUPLEX]   = s_r.full_duplex;
  end

  always_comb begin
    stat_word = 16'h0000;
    stat_word[`PBMC_S_FIXED]       = `PBMC_FIXED_VAL;
    stat_word[`PBMC_S_LINK_LL]     = link_ll;
    stat_word[`PBMC_S_FAULT_LH]    = fault_lh;
    stat_word[`PBMC_S_RSTDONE_COR] = rstdone_cor;
    stat_word[`PBMC_S_DEAD_SC]     = dead_sc;
  end

  always_comb begin
    s_nxt          = s_r;
    s_nxt.pready   = 1'b0;
    s_nxt.pslverr  = 1'b0;
    s_nxt.rst_done = 1'b0;

    // one wait state keeps read data coming from a flop
    if (psel && penable && !s_r.pready) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = !(hit_ctrl || hit_stat);
      s_nxt.prdata  = 32'h0000_0000;
      if (!pwrite && hit_ctrl) begin
        s_nxt.prdata = {16'h0000, ctrl_word};
      end else if (!pwrite && hit_stat) begin
        s_nxt.prdata = {16'h0000, stat_word};
      end
    end

    unique case (s_r.fsm)
      pbmc_pkg::PBMC_BOOT: begin
        // wait for the synchroniser to carry the strap pins through
        s_nxt.rst_cnt = s_r.rst_cnt + 8'h01;
        if (s_r.rst_cnt == 8'(`PBMC_BOOT_CYC)) begin
          s_nxt.fsm         = pbmc_pkg::PBMC_RUN;
          s_nxt.rst_cnt     = 8'h00;
          s_nxt.loopback    = `PBMC_LOOPBACK_RST;
          s_nxt.speed_100   = p.strap_speed_100;
          s_nxt.full_duplex = p.strap_full_duplex;
          s_nxt.an_en = p.strap_an_en && !p.fiber_mode_enable;
        end
      end
      pbmc_pkg::PBMC_RUN: begin
        if (wr_ctrl && pwdata[`PBMC_B_RESET]) begin
          // reset overrides the rest of the same write
          s_nxt.fsm     = pbmc_pkg::PBMC_SWRST;
          s_nxt.rst_cnt = 8'h00;
        end else if (wr_ctrl) begin
          s_nxt.loopback    = pwdata[`PBMC_B_LOOPBACK];
          s_nxt.speed_100   = pwdata[`PBMC_B_SPEED];
          s_nxt.an_en       = pwdata[`PBMC_B_AN_EN];
          s_nxt.full_duplex = pwdata[`PBMC_B_DUPLEX];
        end
      end
      pbmc_pkg::PBMC_SWRST: begin
        // control writes are dropped until the port is back
        s_nxt.rst_cnt = s_r.rst_cnt + 8'h01;
        if (s_r.rst_cnt == 8'(`PBMC_SWRST_CYC - 1)) begin
          s_nxt.fsm         = pbmc_pkg::PBMC_RUN;
          s_nxt.rst_cnt     = 8'h00;
          s_nxt.rst_done    = 1'b1;
          s_nxt.loopback    = `PBMC_LOOPBACK_RST;
          s_nxt.speed_100   = p.strap_speed_100;
          s_nxt.full_duplex = p.strap_full_duplex;
          s_nxt.an_en = p.strap_an_en && !p.fiber_mode_enable;
        end
      end
      default: begin
        s_nxt.fsm     = pbmc_pkg::PBMC_BOOT;
        s_nxt.rst_cnt = 8'h00;
      end
    endcase

    // descrambler resync window after loopback turns on
    if (!s_nxt.loopback) begin
      s_nxt.dead_cnt = 16'h0000;
    end else if (!s_r.loopback) begin
      s_nxt.dead_cnt = 16'(DEAD_CYC);
    end else if (s_r.dead_cnt != 16'h0000) begin
      s_nxt.dead_cnt = s_r.dead_cnt - 16'h0001;
    end

    // negotiation result overrides the manual bits
    s_nxt.mode.an_enable   = s_nxt.an_en;
    s_nxt.mode.speed_100   = s_nxt.an_en ? p.an_speed_100
                                         : s_nxt.speed_100;
    s_nxt.mode.full_duplex = s_nxt.an_en ? p.an_full_duplex
                                         : s_nxt.full_duplex;
    s_nxt.mode.loopback    = s_nxt.loopback;
    s_nxt.mode.port_reset  = (s_nxt.fsm != pbmc_pkg::PBMC_RUN);

    // loopback also keeps line data from reaching the receive side
    if (s_nxt.loopback) begin
      s_nxt.rx.rxd   = p.txd;
      s_nxt.rx.rx_dv = p.tx_en && (s_nxt.dead_cnt == 16'h0000);
    end else begin
      s_nxt.rx.rxd   = p.line_rxd;
      s_nxt.rx.rx_dv = p.line_rx_dv;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata  = s_r.prdata;
  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign rx      = s_r.rx;
  assign mode    = s_r.mode;
endmodule

// ---- bench/pbmc_checker.sv ----
// assertion checker for the mode control block
`timescale 1ns/1ps
module pbmc_checker #(
  parameter int unsigned DEAD_CYC = 20
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire pbmc_pkg::pbmc_pins_t pins,
  input wire pbmc_pkg::pbmc_rx_t   rx,
  input wire pbmc_pkg::pbmc_mode_t mode
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic done = psel && penable && pready;
  property p_swrst;
    done && pwrite && paddr == 8'h00 && pwdata[15] && !mode.port_reset
      |=> mode.port_reset;
  endproperty
  a_swrst: assert property (p_swrst) else $error("no soft reset");
  property p_swend;
    mode.port_reset |-> ##[1:120] !mode.port_reset;
  endproperty
  a_swend: assert property (p_swend) else $error("reset stuck");
  property p_loop;
    rx.rx_dv && mode.loopback |-> rx.rxd == $past(pins.txd, 3);
  endproperty
  a_loop: assert property (p_loop) else $error("loop data");
  property p_dead;
    $rose(mode.loopback) |-> !rx.rx_dv [*8];
  endproperty
  a_dead: assert property (p_dead) else $error("dead time");
  // full span kept in a counter, a repeat that long would not unroll
  int unsigned dead_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dead_n <= '0;
    end else if (!mode.loopback) begin
      dead_n <= '0;
    end else if (dead_n < DEAD_CYC) begin
      dead_n <= dead_n + 32'h0000_0001;
    end
  end
  property p_dead_span;
    mode.loopback && dead_n < DEAD_CYC |-> !rx.rx_dv;
  endproperty
  a_dead_span: assert property (p_dead_span) else $error("dead span");
  // mode outputs must follow the register bits when negotiation is off
  property p_manual;
    done && !pwrite && paddr == 8'h00 && !mode.an_enable && !mode.port_reset
      |-> prdata[13] == mode.speed_100 && prdata[8] == mode.full_duplex;
  endproperty
  a_manual: assert property (p_manual) else $error("manual");
  property p_strap;
    $fell(mode.port_reset) && !$past(pins.fiber_mode_enable, 6)
      |-> mode.an_enable == $past(pins.strap_an_en, 6);
  endproperty
  a_strap: assert property (p_strap) else $error("strap an");
  property p_fiber;
    $fell(mode.port_reset) && $past(pins.fiber_mode_enable, 6)
      |-> !mode.an_enable;
  endproperty
  a_fiber: assert property (p_fiber) else $error("fiber an");
  property p_auto;
    mode.an_enable && $past(mode.an_enable) && !mode.port_reset
      |-> mode.speed_100 == $past(pins.an_speed_100, 3)
      && mode.full_duplex == $past(pins.an_full_duplex, 3);
  endproperty
  a_auto: assert property (p_auto) else $error("auto mode");
  property p_fixed;
    done && !pwrite && paddr == 8'h04 |-> prdata[0] && !pslverr;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bit");
  c_loop: cover property ($rose(mode.loopback));
  c_swrst: cover property ($rose(mode.port_reset));
  c_err: cover property (pready && pslverr);
endmodule

bind pbmc_top pbmc_checker #(.DEAD_CYC(DEAD_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins(pins), .rx(rx), .mode(mode)
);

// ---- bench/pbmc_apb_model.sv ----
// management controller model, apb master
`timescale 1ns/1ps
module pbmc_apb_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // no latency assumed: waits on pready, bench watchdog bounds it
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data no longer shows the last word
    pwdata <= ~d;
  endtask
endmodule

// ---- bench/tb_phy_basic_mode_control.sv ----
// self-checking bench for the mode control block
`timescale 1ns/1ps
module tb_phy_basic_mode_control;
  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  pbmc_pkg::pbmc_pins_t pins_d;
  pbmc_pkg::pbmc_rx_t   rx;
  pbmc_pkg::pbmc_mode_t mode;
  int                   err_count;
  int                   num_checks;
  int                   n;
  logic [31:0]          v;
  logic                 e;

  always #5 pclk = ~pclk;

  pbmc_top #(.DEAD_CYC(20)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins_d), .rx(rx),
    .mode(mode));
  pbmc_apb_model u_mgr (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    u_mgr.xfer(1'b0, a, 32'h0, v, e);
    chk(v, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_mgr.xfer(1'b1, a, d, v, e);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic complete_run;
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    err_count = 0;
    num_checks = 0;
    pins_d = '0;
    pins_d.link_ok = 1'b1;
    pins_d.strap_an_en = 1'b1;
    pins_d.strap_speed_100 = 1'b1;
    pins_d.an_full_duplex = 1'b1;
    pins_d.txd = 4'ha;
    pins_d.tx_en = 1'b1;
    pins_d.line_rxd = 4'h5;
    pins_d.line_rx_dv = 1'b1;
    cyc(2);
    presetn <= 1'b1;
    cyc(12);
    rd(8'h00, 32'h3000);
    chk({27'h0, mode}, 32'h0c);
    chk({27'h0, rx}, 32'h0b);
    wr(8'h04, 32'hffff);
    // link reads down until a read after reset has reported it
    rd(8'h04, 32'h1);
    pins_d.link_ok <= 1'b0;
    pins_d.remote_fault <= 1'b1;
    cyc(5);
    pins_d.link_ok <= 1'b1;
    pins_d.remote_fault <= 1'b0;
    cyc(5);
    rd(8'h04, 32'h5);
    rd(8'h04, 32'h3);
    rd(8'h08, 32'h0);
    chk({31'h0, e}, 32'h1);
    // loopback with negotiation off, manual speed_100 clear, full duplex
    wr(8'h00, 32'h4100);
    cyc(1);
    chk({27'h0, mode}, 32'h0a);
    chk({31'h0, rx.rx_dv}, 32'h0);
    rd(8'h04, 32'h13);
    cyc(30);
    chk({27'h0, rx}, 32'h15);
    pins_d.txd <= 4'h3;
    cyc(4);
    chk({27'h0, rx}, 32'h07);
    rd(8'h04, 32'h3);
    // fiber must override the negotiation strap on soft reset
    pins_d.fiber_mode_enable <= 1'b1;
    pins_d.strap_full_duplex <= 1'b1;
    cyc(5);
    wr(8'h00, 32'h8000);
    u_mgr.xfer(1'b0, 8'h00, 32'h0, v, e);
    chk({31'h0, v[15]}, 32'h1);
    wr(8'h00, 32'h4000);
    n = 0;
    do begin
      u_mgr.xfer(1'b0, 8'h00, 32'h0, v, e);
      n++;
    end while (v[15] === 1'b1 && n < 60);
    chk({31'h0, v[15]}, 32'h0);
    rd(8'h00, 32'h2100);
    chk({27'h0, mode}, 32'h18);
    rd(8'h04, 32'hb);
    rd(8'h04, 32'h3);
    complete_run();
  end

  initial begin
    cyc(5000);
    err_count++;
    complete_run();
  end
endmodule
